// file: dcv_ctrl.sv
`timescale 1ns/1ns
`include "dcv_defs.svh"
module dcv_ctrl #(
  parameter int NCH = `DCV_NUM_CH
) (
  input wire logic clk,
  input wire logic srst,
  // Link to the processor side
  dcv_if.ctrl bus,
  // Direct peripheral requests
  input wire logic watchdog_irq,
  input wire logic dbg_rx_irq,
  input wire logic dbg_tx_irq,
  input wire logic [`DCV_NUM_TIMERS*`DCV_TIMER_FLAGS-1:0] timer_flags,
  input wire logic usb_hi_irq,
  input wire logic usb_lo_irq,
  input wire logic clock_unit_irq,
  input wire logic enet_dma_irq,
  input wire logic [`DCV_NUM_DMA-1:0] dma_ch_irq,
  input wire logic can_irq,
  input wire logic motor_irq,
  input wire logic adc_irq,
  input wire logic [`DCV_NUM_UARTS*`DCV_UART_FLAGS-1:0] uart_flags,
  input wire logic [`DCV_NUM_I2C*`DCV_I2C_FLAGS-1:0] i2c_flags,
  input wire logic ssp0_irq,
  input wire logic ssp1_irq,
  input wire logic brownout_irq,
  input wire logic rtc_irq,
  input wire logic usb_resume_irq,
  input wire logic prefetch_branch_cache_source,
  // Wake-up unit: 32 pins, calendar, bus resume
  input wire logic [`DCV_NUM_WAKE-1:0] wake_in
);
  // Both units are wired at sixteen channels, so other counts cannot be served
  if (NCH != `DCV_NUM_CH) begin : g_bad_nch
    $error("dcv_ctrl: only 32 channels supported");
  end

  ////////////////////////////////////////////////////////////////////////
  // Raw source vector, level inputs straight from same-clock logic
  // No synchronisers: every source is a level from logic on this clock
  logic [NCH-1:0] raw_src;
  logic [`DCV_NUM_WAKE_GRPS-1:0] wake_grp;
  logic [NCH-1:0] force_reg;

  // Grouped sources reduce to one level per channel
  genvar g;
  generate
    for (g = 0; g < `DCV_NUM_WAKE_GRPS; g++) begin : g_wake
      assign wake_grp[g] = |wake_in[g*`DCV_WAKE_GRP +: `DCV_WAKE_GRP];
    end
    for (g = 0; g < `DCV_NUM_TIMERS; g++) begin : g_tim
      assign raw_src[`DCV_CH_TIMER0+g] = |timer_flags[g*`DCV_TIMER_FLAGS +: `DCV_TIMER_FLAGS];
    end
    for (g = 0; g < `DCV_NUM_UARTS; g++) begin : g_uart
      assign raw_src[`DCV_CH_UART0+g] = |uart_flags[g*`DCV_UART_FLAGS +: `DCV_UART_FLAGS];
    end
    for (g = 0; g < `DCV_NUM_I2C; g++) begin : g_i2c
      assign raw_src[`DCV_CH_I2C0+g] = |i2c_flags[g*`DCV_I2C_FLAGS +: `DCV_I2C_FLAGS];
    end
    for (g = 0; g < `DCV_NUM_WAKE_GRPS; g++) begin : g_wch
      assign raw_src[`DCV_CH_WAKE_GRP0+g] = wake_grp[g];
    end
  endgenerate

  // Fixed single-source channels
  assign raw_src[`DCV_CH_WATCHDOG] = watchdog_irq;
  assign raw_src[`DCV_CH_SOFT] = 1'b0;
  assign raw_src[`DCV_CH_DBG_RX] = dbg_rx_irq;
  assign raw_src[`DCV_CH_DBG_TX] = dbg_tx_irq;
  // Remaining slots carry peripheral levels; the DMA and wake-all slots OR their input groups
  assign raw_src[8] = usb_hi_irq;
  assign raw_src[9] = usb_lo_irq;
  assign raw_src[10] = clock_unit_irq;
  assign raw_src[`DCV_CH_ENET] = enet_dma_irq;
  assign raw_src[`DCV_CH_DMA] = |dma_ch_irq;
  assign raw_src[13] = can_irq;
  assign raw_src[14] = motor_irq;
  assign raw_src[15] = adc_irq;
  assign raw_src[21] = ssp0_irq;
  assign raw_src[22] = ssp1_irq;
  assign raw_src[23] = brownout_irq;
  assign raw_src[24] = rtc_irq;
  assign raw_src[`DCV_CH_WAKE_ALL] = |wake_in;
  assign raw_src[`DCV_CH_USB_RESUME] = usb_resume_irq;
  assign raw_src[`DCV_CH_PREFETCH] = prefetch_branch_cache_source;

  ////////////////////////////////////////////////////////////////////////
  // Firmware configuration storage
  logic [4:0] chan_src [NCH];
  logic [31:0] chan_vect [NCH];
  logic [5:0] fast_sel;
  logic cmd_map, cmd_vect, cmd_fast, cmd_force, cmd_read;

  // One strobe per op code; unknown codes decode to nothing
  assign cmd_map = bus.cmd_valid && bus.cmd_op == `DCV_CMD_MAP;
  assign cmd_vect = bus.cmd_valid && bus.cmd_op == `DCV_CMD_VECT;
  assign cmd_fast = bus.cmd_valid && bus.cmd_op == `DCV_CMD_FAST_SEL;
  assign cmd_force = bus.cmd_valid && bus.cmd_op == `DCV_CMD_FORCE;
  assign cmd_read = bus.cmd_valid && bus.cmd_op == `DCV_CMD_READ;

  // Map only within the same unit: the top source bit is kept from the channel
  // Reset returns every channel to its own source with a zero vector
  generate
    for (g = 0; g < NCH; g++) begin : g_cfg
      // Unit of this channel; a map can never move a source across units
      localparam bit UNIT_SEL = 1'(g / `DCV_UNIT_CH);
      always_ff @(posedge clk) begin
        if (srst) begin
          chan_src[g] <= 5'(g);
          chan_vect[g] <= '0;
          force_reg[g] <= 1'b0;
        end else begin
          if (cmd_map && bus.cmd_chan == 5'(g)) begin
            chan_src[g] <= {UNIT_SEL, bus.cmd_src[3:0]};
          end
          if (cmd_vect && bus.cmd_chan == 5'(g)) begin
            chan_vect[g] <= bus.cmd_data;
          end
          if (cmd_force && bus.cmd_chan == 5'(g)) begin
            force_reg[g] <= bus.cmd_data[0];
          end
        end
      end
    end
  endgenerate

  // Fast steering: bit 5 enables, low bits pick the source
  always_ff @(posedge clk) begin
    if (srst) begin
      fast_sel <= `DCV_FAST_OFF;
    end else if (cmd_fast) begin
      fast_sel <= {bus.cmd_data[0], bus.cmd_src};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Effective requests: source level or forced, steered one removed
  logic [NCH-1:0] src_req, chan_req;
  assign src_req = raw_src | force_reg;

  // Each channel follows the level of its mapped source
  generate
    for (g = 0; g < NCH; g++) begin : g_req
      assign chan_req[g] = src_req[chan_src[g]] && !(fast_sel[5] && fast_sel[4:0] == chan_src[g]);
    end
  endgenerate

  // Outputs driven combinationally; no lookup on the fast path
  // Steered source is dropped from the vectored path so it cannot fire twice
  assign bus.fast_request_out = fast_sel[5] && src_req[fast_sel[4:0]];
  assign bus.normal_request_out = |chan_req;

  ////////////////////////////////////////////////////////////////////////
  // Two chained units; primary pending wins outright
  logic p_any, s_any;
  logic [3:0] p_idx, s_idx;
  logic [4:0] win_ch;

  dcv_prio_unit #(.CH(`DCV_UNIT_CH), .IW(`DCV_UNIT_IDX_W)) u_primary_vector_unit (
    .pend(chan_req[15:0]),
    .any(p_any),
    .idx(p_idx)
  );
  dcv_prio_unit #(.CH(`DCV_UNIT_CH), .IW(`DCV_UNIT_IDX_W)) u_secondary_vector_unit (
    .pend(chan_req[31:16]),
    .any(s_any),
    .idx(s_idx)
  );
  // Secondary only answers when the primary has nothing pending
  assign win_ch = p_any ? {1'b0, p_idx} : {1'b1, s_idx};

  // Read answer one cycle after the strobe; vector always ready for fetch
  // Result is captured at the strobe and held, so late source changes cannot tear it
  always_ff @(posedge clk) begin
    if (srst) begin
      bus.rd_valid <= 1'b0;
      bus.rd_source <= '0;
      bus.rd_vector <= '0;
      bus.rd_none <= 1'b1;
    end else begin
      bus.rd_valid <= cmd_read;
      if (cmd_read) begin
        bus.rd_source <= chan_src[win_ch];
        bus.rd_vector <= chan_vect[win_ch];
        bus.rd_none <= !(p_any || s_any);
      end
    end
  end
endmodule

// file: dcv_defs.svh
`ifndef DCV_DEFS_SVH
`define DCV_DEFS_SVH
// Channel counts
`define DCV_NUM_CH 32
`define DCV_UNIT_CH 16
`define DCV_CH_IDX_W 5
`define DCV_UNIT_IDX_W 4
// Fixed channel assignments
`define DCV_CH_WATCHDOG 0
`define DCV_CH_SOFT 1
`define DCV_CH_DBG_RX 2
`define DCV_CH_DBG_TX 3
`define DCV_CH_TIMER0 4
`define DCV_CH_ENET 11
`define DCV_CH_DMA 12
`define DCV_CH_UART0 16
`define DCV_CH_I2C0 19
`define DCV_CH_WAKE_ALL 25
`define DCV_CH_WAKE_GRP0 26
`define DCV_CH_USB_RESUME 30
`define DCV_CH_PREFETCH 31
// Source group sizes
`define DCV_NUM_TIMERS 4
`define DCV_TIMER_FLAGS 5
`define DCV_NUM_DMA 8
`define DCV_NUM_UARTS 3
`define DCV_UART_FLAGS 5
`define DCV_NUM_I2C 2
`define DCV_I2C_FLAGS 3
`define DCV_NUM_WAKE 32
`define DCV_WAKE_GRP 8
`define DCV_NUM_WAKE_GRPS 4
// Firmware command codes
`define DCV_CMD_NONE 3'h0
`define DCV_CMD_MAP 3'h1
`define DCV_CMD_VECT 3'h2
`define DCV_CMD_FAST_SEL 3'h3
`define DCV_CMD_FORCE 3'h4
`define DCV_CMD_READ 3'h5
// Reset values
`define DCV_FAST_OFF 6'h00
`endif

// file: dcv_pkg.sv
package dcv_pkg;
  typedef logic [31:0] dcv_word_t;
  typedef enum logic [2:0] {
    DCV_OP_NONE,
    DCV_OP_MAP,
    DCV_OP_VECT,
    DCV_OP_FAST_SEL,
    DCV_OP_FORCE,
    DCV_OP_READ
  } dcv_op_t;
endpackage

// file: dcv_if.sv
`timescale 1ns/1ns
interface dcv_if;
  // Firmware command strobe
  logic cmd_valid;
  logic [2:0] cmd_op;
  logic [4:0] cmd_chan;
  logic [4:0] cmd_src;
  logic [31:0] cmd_data;
  // Answer and requests to the core
  logic rd_valid;
  logic [4:0] rd_source;
  logic [31:0] rd_vector;
  logic rd_none;
  logic fast_request_out;
  logic normal_request_out;
  modport ctrl (input cmd_valid, cmd_op, cmd_chan, cmd_src, cmd_data,
                output rd_valid, rd_source, rd_vector, rd_none, fast_request_out, normal_request_out);
  modport core (output cmd_valid, cmd_op, cmd_chan, cmd_src, cmd_data,
                input rd_valid, rd_source, rd_vector, rd_none, fast_request_out, normal_request_out);
endinterface

// file: dcv_prio_unit.sv
`timescale 1ns/1ns
module dcv_prio_unit #(
  parameter int CH = 16,
  parameter int IW = 4
) (
  // Pending channels of one unit
  input wire logic [CH-1:0] pend,
  // Lowest set channel
  output logic any,
  output logic [IW-1:0] idx
);
  if (CH > (1 << IW)) begin : g_bad_iw
    $error("dcv_prio_unit: index too narrow");
  end

  ////////////////////////////////////////////////////////////////////////
  // Lowest index wins, scanned from the top so the last hit stays
  always_comb begin
    any = |pend;
    idx = '0;
    for (int i = CH - 1; i >= 0; i--) begin
      if (pend[i]) begin
        idx = IW'(i);
      end
    end
  end
endmodule

// file: dcv_core.sv
`timescale 1ns/1ns
`include "dcv_defs.svh"
module dcv_core (
  input wire logic clk,
  input wire logic srst,
  // Link to the controller
  dcv_if.core bus,
  // Firmware user side
  input wire logic user_valid,
  input wire logic [2:0] user_op,
  input wire logic [4:0] user_chan,
  input wire logic [4:0] user_src,
  input wire logic [31:0] user_data,
  output logic user_busy,
  // Service status
  output logic fast_pending,
  output logic normal_pending,
  output logic [4:0] served_source,
  output logic [31:0] served_vector,
  output logic served_valid
);
  typedef enum logic [1:0] {DCV_IDLE, DCV_WAIT} dcv_state_t;
  dcv_state_t state, next_state;

  ////////////////////////////////////////////////////////////////////////
  // Forward one command per cycle; a read holds off until answered
  logic issue;
  assign issue = user_valid && state == DCV_IDLE;
  assign user_busy = state != DCV_IDLE;

  always_comb begin
    next_state = state;
    case (state)
      DCV_IDLE: if (issue && user_op == `DCV_CMD_READ) next_state = DCV_WAIT;
      DCV_WAIT: if (bus.rd_valid) next_state = DCV_IDLE;
      default: next_state = DCV_IDLE;
    endcase
  end

  // Command registers; the far end samples them one cycle later
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= DCV_IDLE;
      bus.cmd_valid <= 1'b0;
      bus.cmd_op <= `DCV_CMD_NONE;
      bus.cmd_chan <= '0;
      bus.cmd_src <= '0;
      bus.cmd_data <= '0;
    end else begin
      state <= next_state;
      bus.cmd_valid <= issue;
      bus.cmd_op <= user_op;
      bus.cmd_chan <= user_chan;
      bus.cmd_src <= user_src;
      bus.cmd_data <= user_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Request levels and captured answer
  always_ff @(posedge clk) begin
    if (srst) begin
      fast_pending <= 1'b0;
      normal_pending <= 1'b0;
      served_source <= '0;
      served_vector <= '0;
      served_valid <= 1'b0;
    end else begin
      fast_pending <= bus.fast_request_out;
      normal_pending <= bus.normal_request_out && !bus.fast_request_out;
      served_valid <= bus.rd_valid && !bus.rd_none;
      if (bus.rd_valid) begin
        served_source <= bus.rd_source;
        served_vector <= bus.rd_vector;
      end
    end
  end
endmodule

// file: dcv_checker.sv
`timescale 1ns/1ns
`include "dcv_defs.svh"
module dcv_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Commands from the core
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_op,
  input wire logic [31:0] cmd_data,
  // Answers and requests to the core
  input wire logic rd_valid,
  input wire logic [4:0] rd_source,
  input wire logic [31:0] rd_vector,
  input wire logic rd_none,
  input wire logic fast_request_out,
  input wire logic normal_request_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////////
  // Command decode
  wire is_read = cmd_valid && cmd_op == `DCV_CMD_READ;
  wire is_force_on = cmd_valid && cmd_op == `DCV_CMD_FORCE && cmd_data[0];
  wire is_fast_on = cmd_valid && cmd_op == `DCV_CMD_FAST_SEL && cmd_data[0];
  // Sticky once steered; conservative, never cleared before reset
  logic fast_armed;
  always_ff @(posedge clk) begin
    if (srst)
      fast_armed <= 1'b0;
    else if (is_fast_on)
      fast_armed <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Properties
  property p_read_answer;
    is_read |=> rd_valid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read got no answer");
  property p_answer_cause;
    rd_valid |-> $past(is_read);
  endproperty
  a_answer_cause: assert property (p_answer_cause) else $error("answer without read");
  property p_answer_pulse;
    rd_valid |=> !rd_valid;
  endproperty
  a_answer_pulse: assert property (p_answer_pulse) else $error("answer longer than one cycle");
  property p_result_hold;
    !rd_valid |-> $stable(rd_source) && $stable(rd_vector) && $stable(rd_none);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result changed without read");
  property p_none_match;
    rd_valid |-> rd_none == !$past(normal_request_out);
  endproperty
  a_none_match: assert property (p_none_match) else $error("none flag disagrees with request");
  property p_force_raises;
    is_force_on |=> normal_request_out || fast_request_out;
  endproperty
  a_force_raises: assert property (p_force_raises) else $error("forced channel raised nothing");
  property p_fast_quiet;
    !fast_armed |-> !fast_request_out;
  endproperty
  a_fast_quiet: assert property (p_fast_quiet) else $error("fast request without steering");
  property p_reset_values;
    $past(srst) && !srst |-> rd_none && !rd_valid && rd_source == 5'h00 && rd_vector == 32'h0;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("answer not cleared by reset");
  // Main scenarios
  c_read_none: cover property (is_read ##1 rd_valid && rd_none);
  c_read_win: cover property (rd_valid && !rd_none);
  c_fast: cover property (fast_request_out && normal_request_out);
endmodule

// file: dcv_tb.sv
`timescale 1ns/1ns
`include "dcv_defs.svh"
module tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic user_valid = 1'b0;
  logic [2:0] user_op = 3'h0;
  logic [4:0] user_chan = 5'h00;
  logic [4:0] user_src = 5'h00;
  logic [31:0] user_data = 32'h0;
  logic user_busy, fast_pending, normal_pending, served_valid;
  logic [4:0] served_source;
  logic [31:0] served_vector;
  // One bit per hardware channel; grouped flags fan out below
  logic [31:0] src = 32'h0;
  logic [31:0] wake_in = 32'h0;
  int fsel = 0;
  logic [19:0] timer_flags;
  logic [7:0] dma_ch_irq;
  logic [14:0] uart_flags;
  logic [5:0] i2c_flags;
  int mismatches = 0;
  int total_checks = 0;
  dcv_if dcv_if_i ();
  ////////////////////////////////////////////////////////////////////////////
  always #5 clk = ~clk;
  // Flag position picked by fsel (set per channel in t_scan), so each group drives one member at a time
  always_comb begin
    timer_flags = 20'h0;
    uart_flags = 15'h0;
    i2c_flags = 6'h0;
    dma_ch_irq = 8'h0;
    for (int t = 0; t < 4; t++)
      timer_flags[5 * t + fsel % 5] = src[4 + t];
    for (int u = 0; u < 3; u++)
      uart_flags[5 * u + fsel % 5] = src[16 + u];
    for (int p = 0; p < 2; p++)
      i2c_flags[3 * p + fsel % 3] = src[19 + p];
    dma_ch_irq[fsel % 8] = src[12];
  end
  dcv_ctrl dcv_ctrl_i (.clk(clk), .srst(srst), .bus(dcv_if_i), .watchdog_irq(src[0]), .dbg_rx_irq(src[2]),
    .dbg_tx_irq(src[3]), .timer_flags(timer_flags), .usb_hi_irq(src[8]), .usb_lo_irq(src[9]),
    .clock_unit_irq(src[10]), .enet_dma_irq(src[11]), .dma_ch_irq(dma_ch_irq), .can_irq(src[13]),
    .motor_irq(src[14]), .adc_irq(src[15]), .uart_flags(uart_flags), .i2c_flags(i2c_flags), .ssp0_irq(src[21]),
    .ssp1_irq(src[22]), .brownout_irq(src[23]), .rtc_irq(src[24]), .usb_resume_irq(src[30]),
    .prefetch_branch_cache_source(src[31]), .wake_in(wake_in));
  dcv_core dcv_core_i (.clk(clk), .srst(srst), .bus(dcv_if_i), .user_valid(user_valid), .user_op(user_op),
    .user_chan(user_chan), .user_src(user_src), .user_data(user_data), .user_busy(user_busy),
    .fast_pending(fast_pending), .normal_pending(normal_pending), .served_source(served_source),
    .served_vector(served_vector), .served_valid(served_valid));
  dcv_checker dcv_checker_i (.clk(clk), .srst(srst), .cmd_valid(dcv_if_i.cmd_valid), .cmd_op(dcv_if_i.cmd_op),
    .cmd_data(dcv_if_i.cmd_data), .rd_valid(dcv_if_i.rd_valid), .rd_source(dcv_if_i.rd_source),
    .rd_vector(dcv_if_i.rd_vector), .rd_none(dcv_if_i.rd_none), .fast_request_out(dcv_if_i.fast_request_out),
    .normal_request_out(dcv_if_i.normal_request_out));
  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] vec(input int ch);
    vec = 32'h00001000 + 32'(ch) * 32'h10;
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Extra idle cycle at the end so back-to-back calls never retoggle valid
  task automatic cmd(input dcv_pkg::dcv_op_t op, input int ch, input int s, input logic [31:0] d);
    int n;
    n = 0;
    while (user_busy !== 1'b0 && n < 50) begin
      @(negedge clk);
      n++;
    end
    user_valid = 1'b1;
    user_op = op;
    user_chan = 5'(ch);
    user_src = 5'(s);
    user_data = d;
    @(negedge clk);
    user_valid = 1'b0;
    @(negedge clk);
  endtask
  // Source and vector only mean something when a request was pending
  task automatic rd_chk(input logic none_exp, input int s_exp, input logic [31:0] v_exp);
    int n;
    n = 0;
    cmd(dcv_pkg::DCV_OP_READ, 0, 0, 32'h0);
    while (user_busy !== 1'b0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("served_valid", {31'h0, !none_exp}, {31'h0, served_valid});
    chk("rd_none", {31'h0, none_exp}, {31'h0, dcv_if_i.rd_none});
    if (!none_exp) begin
      chk("served_source", 32'(s_exp), {27'h0, served_source});
      chk("served_vector", v_exp, served_vector);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_scan();
    for (int ch = 0; ch < 32; ch++)
      cmd(dcv_pkg::DCV_OP_VECT, ch, 0, vec(ch));
    for (int ch = 0; ch < 32; ch++) begin
      if (ch == 1 || (ch >= 25 && ch <= 29))
        continue;
      fsel = ch;
      src = 32'h1 << ch;
      @(negedge clk);
      chk("normal_request_out", 32'h1, {31'h0, dcv_if_i.normal_request_out});
      chk("normal_pending", 32'h1, {31'h0, normal_pending});
      rd_chk(1'b0, ch, vec(ch));
    end
    src = 32'h0;
  endtask
  task automatic t_prio();
    src = 32'h00100028;
    rd_chk(1'b0, 3, vec(3));
    src = 32'h00100020;
    rd_chk(1'b0, 5, vec(5));
    cmd(dcv_pkg::DCV_OP_MAP, 16, 31, 32'h0);
    src = 32'h80008000;
    rd_chk(1'b0, 15, vec(15));
    src = 32'h80000000;
    rd_chk(1'b0, 31, vec(16));
    cmd(dcv_pkg::DCV_OP_MAP, 16, 16, 32'h0);
    src = 32'h0;
  endtask
  task automatic t_wake();
    wake_in = 32'h00000004;
    rd_chk(1'b0, 25, vec(25));
    cmd(dcv_pkg::DCV_OP_FAST_SEL, 0, 25, 32'h1);
    for (int g = 0; g < 4; g++) begin
      wake_in = 32'h1 << (8 * g + 7 - g);
      @(negedge clk);
      chk("fast_request_out", 32'h1, {31'h0, dcv_if_i.fast_request_out});
      chk("fast_pending", 32'h1, {31'h0, fast_pending});
      chk("normal_pending", 32'h0, {31'h0, normal_pending});
      rd_chk(1'b0, 26 + g, vec(26 + g));
    end
    cmd(dcv_pkg::DCV_OP_FAST_SEL, 0, 25, 32'h0);
    wake_in = 32'h0;
    rd_chk(1'b1, 0, 32'h0);
  endtask
  task automatic t_force();
    cmd(dcv_pkg::DCV_OP_FORCE, 1, 0, 32'h1);
    cmd(dcv_pkg::DCV_OP_FORCE, 31, 0, 32'h1);
    rd_chk(1'b0, 1, vec(1));
    cmd(dcv_pkg::DCV_OP_FORCE, 1, 0, 32'h0);
    rd_chk(1'b0, 31, vec(31));
    srst = 1'b1;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    chk("normal_request_out", 32'h0, {31'h0, dcv_if_i.normal_request_out});
    rd_chk(1'b1, 0, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (mismatches == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Whole run is a few hundred cycles; this is far beyond it
  initial begin
    #200000;
    mismatches++;
    wrap_up();
  end
  initial begin
    repeat (10) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    rd_chk(1'b1, 0, 32'h0);
    t_scan();
    t_prio();
    t_wake();
    t_force();
    wrap_up();
  end
endmodule
